/* File: rtl/ssr_pkg.sv */
// package: offsets, field positions, reset values and carrier types
package ssr_pkg;
    localparam logic [7:0] SSR_OFF_BUS_CTRL = 8'h0B;
    localparam logic [7:0] SSR_OFF_DMA_STAT = 8'h0C;
    localparam logic [7:0] SSR_OFF_SCSI_STAT = 8'h0D;
    localparam logic [7:0] SSR_RST_BUS_CTRL = 8'h00;
    localparam logic [7:0] SSR_RST_DMA_STAT = 8'h80;
    localparam logic [7:0] SSR_RST_SCSI_STAT = 8'h00;
    // dma status bit positions
    localparam int SSR_DS_FIFO_EMPTY = 7;
    localparam int SSR_DS_ABORT = 4;
    localparam int SSR_DS_STEP = 3;
    localparam int SSR_DS_SCRIPT_INT = 2;
    localparam int SSR_DS_WATCHDOG = 1;
    localparam int SSR_DS_ILLEGAL = 0;
    localparam logic [7:0] SSR_DS_EVENT_MASK = 8'h1F;
    // scsi status bit positions
    localparam int SSR_SS_MISMATCH = 7;
    localparam int SSR_SS_COMPLETE = 6;
    localparam int SSR_SS_TIMEOUT = 5;
    localparam int SSR_SS_SELECTED = 4;
    localparam int SSR_SS_GROSS = 3;
    localparam int SSR_SS_DISCONNECT = 2;
    localparam int SSR_SS_BUS_RESET = 1;
    localparam int SSR_SS_PARITY = 0;
    // control bit positions
    localparam int SSR_DC_SINGLE_STEP = 4;
    localparam int SSR_DC_PIPELINE = 3;
    localparam int SSR_C0_PAR_CHECK = 3;
    localparam int SSR_C0_PAR_PASS = 2;
    localparam int SSR_C0_TARGET = 0;
    localparam int SSR_IS_ABORT = 7;
    // disconnect-legal message codes
    localparam logic [7:0] SSR_MSG_DISCONNECT = 8'h04;
    localparam logic [7:0] SSR_MSG_COMPLETE = 8'h00;
    // selection time-out, 250 ms at 125 MHz
    localparam longint SSR_CLK_HZ = 125000000;
    localparam longint SSR_SEL_TIMEOUT_MS = 250;
    localparam longint SSR_SEL_TIMEOUT_CYC = SSR_SEL_TIMEOUT_MS * SSR_CLK_HZ / 1000;
    // synchronous prescale codes
    typedef enum logic [1:0] {
        SSR_PRE_ASYNC,
        SSR_PRE_DIV10,
        SSR_PRE_DIV15,
        SSR_PRE_DIV20
    } ssr_prescale_e;
    // live scsi control lines, bit 7 down to 0
    typedef struct packed {
        logic req;
        logic ack;
        logic bsy;
        logic sel;
        logic atn;
        logic msg;
        logic cd;
        logic io;
    } ssr_lines_s;
    // one-cycle event pulses from the script engine and dma
    typedef struct packed {
        logic ext_abort;
        logic instr_done;
        logic branch;
        logic int_instr;
        logic master_mode;
        logic illegal_fetch;
        logic indirect_move;
        logic wait_disc_resel;
    } ssr_dma_ev_s;
    // one-cycle scsi event pulses plus qualifiers
    typedef struct packed {
        logic req_edge;
        logic [2:0] expected_phase;
        logic low_level;
        logic arb_done;
        logic sel_start;
        logic sel_response;
        logic selected_by_other;
        logic gross_error;
        logic disconnect;
        logic [7:0] last_msg_in;
        logic rst_line;
        logic scsi_par_err;
        logic host_par_err;
    } ssr_scsi_ev_s;
endpackage

/* File: rtl/ssr_sel_timer.sv */
// selection / reselection time-out counter
`timescale 1ns/100ps
`default_nettype none
module ssr_sel_timer
    import ssr_pkg::*;
#(
    parameter longint TIMEOUT_CYC = SSR_SEL_TIMEOUT_CYC
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic start_i,
    input wire logic respond_i,
    output logic expired_o
);
    logic [31:0] count;
    logic running;
    wire last_tick = running && (count == 32'(TIMEOUT_CYC - 1));

    // counts from start until a response arrives or the limit passes
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count <= 32'h0;
            running <= 1'b0;
            expired_o <= 1'b0;
        end else begin
            expired_o <= last_tick && !respond_i;
            if (start_i) begin
                count <= 32'h0;
                running <= 1'b1;
            end else if (respond_i || last_tick) begin
                running <= 1'b0;
            end else if (running) begin
                count <= count + 32'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/ssr_status_regs.sv */
// status and interrupt-reporting register bank
`timescale 1ns/100ps
`default_nettype none
module ssr_status_regs
    import ssr_pkg::*;
#(
    parameter longint SEL_TIMEOUT_CYC = SSR_SEL_TIMEOUT_CYC
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire ssr_lines_s lines_i,
    input wire logic fifo_empty_i,
    input wire logic [7:0] dma_control_i,
    input wire logic [7:0] control_0_i,
    input wire logic selection_enable_i,
    input wire logic assert_reset_i,
    input wire logic parity_gen_en_i,
    input wire logic [2:0] latch_phase_i,
    input wire logic [7:0] dma_interrupt_enable_i,
    input wire logic [7:0] scsi_interrupt_enable_i,
    input wire logic [7:0] interrupt_status_wr_i,
    input wire logic interrupt_status_we_i,
    input wire logic watchdog_zero_i,
    input wire ssr_dma_ev_s dma_ev_i,
    input wire ssr_scsi_ev_s scsi_ev_i,
    output logic [7:0] rdata_o,
    output logic [1:0] sync_clock_prescale_o,
    output logic irq_n_o
);
    logic [7:0] dma_flags;
    logic [7:0] scsi_flags;
    logic [1:0] prescale;
    logic rst_seen;
    logic sel_expired;

    // decode of the slave cycle
    wire rd_bus = rd_i && (addr_i == SSR_OFF_BUS_CTRL);
    wire rd_dma = rd_i && (addr_i == SSR_OFF_DMA_STAT);
    wire rd_scsi = rd_i && (addr_i == SSR_OFF_SCSI_STAT);
    wire wr_bus = wr_i && (addr_i == SSR_OFF_BUS_CTRL);

    // dma-class event sources
    wire target_mode = control_0_i[SSR_C0_TARGET];
    wire pipe_on = dma_control_i[SSR_DC_PIPELINE];
    wire sw_abort = interrupt_status_we_i &&
        interrupt_status_wr_i[SSR_IS_ABORT];
    wire ev_abort = (dma_ev_i.ext_abort && parity_gen_en_i) ||
        sw_abort;
    wire ev_step = (dma_ev_i.instr_done &&
        dma_control_i[SSR_DC_SINGLE_STEP]) ||
        (dma_ev_i.branch && pipe_on);
    wire ev_sir = dma_ev_i.int_instr;
    wire ev_wtd = watchdog_zero_i && dma_ev_i.master_mode;
    // wrong-role move is flagged by the fetch unit against target_mode
    wire ev_opc = dma_ev_i.illegal_fetch ||
        (dma_ev_i.indirect_move && pipe_on) ||
        dma_ev_i.wait_disc_resel;

    logic [7:0] dma_set;
    always_comb begin
        dma_set = 8'h00;
        dma_set[SSR_DS_ABORT] = ev_abort;
        dma_set[SSR_DS_STEP] = ev_step;
        dma_set[SSR_DS_SCRIPT_INT] = ev_sir;
        dma_set[SSR_DS_WATCHDOG] = ev_wtd;
        dma_set[SSR_DS_ILLEGAL] = ev_opc;
    end

    // scsi-class event sources
    wire phase_bad = scsi_ev_i.req_edge && ({lines_i.msg, lines_i.cd,
        lines_i.io} != (scsi_ev_i.low_level ? latch_phase_i :
        scsi_ev_i.expected_phase));
    wire ev_ma = target_mode ? lines_i.atn : phase_bad;
    wire ev_cmp = scsi_ev_i.arb_done;
    wire ev_sel = scsi_ev_i.selected_by_other &&
        selection_enable_i;
    wire ev_sge = scsi_ev_i.gross_error;
    wire legal_msg = (scsi_ev_i.last_msg_in == SSR_MSG_DISCONNECT) ||
        (scsi_ev_i.last_msg_in == SSR_MSG_COMPLETE);
    wire ev_udc = scsi_ev_i.disconnect && !target_mode &&
        (scsi_ev_i.low_level || !legal_msg);
    wire rst_level = scsi_ev_i.rst_line || assert_reset_i;
    wire ev_rst = rst_level && !rst_seen;
    wire par_on = control_0_i[SSR_C0_PAR_CHECK];
    wire host_par = control_0_i[SSR_C0_PAR_CHECK] &&
        !control_0_i[SSR_C0_PAR_PASS];
    wire ev_par = par_on && (scsi_ev_i.scsi_par_err ||
        (host_par && scsi_ev_i.host_par_err));

    logic [7:0] scsi_set;
    always_comb begin
        scsi_set = 8'h00;
        scsi_set[SSR_SS_MISMATCH] = ev_ma;
        scsi_set[SSR_SS_COMPLETE] = ev_cmp;
        scsi_set[SSR_SS_TIMEOUT] = sel_expired;
        scsi_set[SSR_SS_SELECTED] = ev_sel;
        scsi_set[SSR_SS_GROSS] = ev_sge;
        scsi_set[SSR_SS_DISCONNECT] = ev_udc;
        scsi_set[SSR_SS_BUS_RESET] = ev_rst;
        scsi_set[SSR_SS_PARITY] = ev_par;
    end

    // selection time-out counter
    ssr_sel_timer #(
        .TIMEOUT_CYC(SEL_TIMEOUT_CYC)
    ) u_sel_timer (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .start_i(scsi_ev_i.sel_start),
        .respond_i(scsi_ev_i.sel_response),
        .expired_o(sel_expired)
    );

    // sticky flags: a set in the read cycle survives the clear
    wire [7:0] next_dma_flags = ((rd_dma ? 8'h00 : dma_flags) |
        dma_set) & SSR_DS_EVENT_MASK;
    wire [7:0] next_scsi_flags = (rd_scsi ? 8'h00 : scsi_flags) |
        scsi_set;

    // read data: the empty bit is the live fifo, never latched
    wire [7:0] dma_view = dma_flags |
        {fifo_empty_i, 7'h00};
    wire [7:0] next_rdata = rd_bus ? lines_i :
        rd_dma ? dma_view :
        rd_scsi ? scsi_flags : 8'h00;

    // irq counts only enabled sources; flags still show masked events
    wire dma_irq = |(next_dma_flags & dma_interrupt_enable_i &
        SSR_DS_EVENT_MASK);
    wire scsi_irq = |(next_scsi_flags &
        scsi_interrupt_enable_i);

    // registers
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dma_flags <= SSR_RST_DMA_STAT & SSR_DS_EVENT_MASK;
            scsi_flags <= SSR_RST_SCSI_STAT;
            prescale <= SSR_RST_BUS_CTRL[1:0];
            rst_seen <= 1'b0;
            rdata_o <= 8'h00;
            irq_n_o <= 1'b1;
        end else begin
            dma_flags <= next_dma_flags;
            scsi_flags <= next_scsi_flags;
            rst_seen <= rst_level;
            rdata_o <= next_rdata;
            irq_n_o <= !(dma_irq || scsi_irq);
            if (wr_bus) begin
                prescale <= wdata_i[1:0];
            end
        end
    end

    assign sync_clock_prescale_o = prescale;

    // checks
    a_live_lines: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) rd_bus |=> rdata_o == $past(lines_i))
        else $error("bus lines read not live");
    a_upper_ignored: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) wr_bus |=> prescale == $past(wdata_i[1:0]))
        else $error("prescale not written");
    a_prescale_hold: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) !wr_bus |=> $stable(prescale))
        else $error("prescale changed without write");
    a_dma_read_clr: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) rd_dma && dma_set == 8'h00 |=>
        dma_flags == 8'h00)
        else $error("dma read did not clear");
    a_dma_mask: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        dma_interrupt_enable_i == 8'h00 && scsi_interrupt_enable_i == 8'h00
        |=> irq_n_o)
        else $error("masked irq asserted");
    a_fifo_live: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) rd_dma |=>
        rdata_o[SSR_DS_FIFO_EMPTY] == $past(fifo_empty_i))
        else $error("fifo empty not live");
    a_abort_set: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) sw_abort |=> dma_flags[SSR_DS_ABORT])
        else $error("software abort lost");
    a_sir_set: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) ev_sir |=> dma_flags[SSR_DS_SCRIPT_INT])
        else $error("script interrupt lost");
    a_rst_once: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) rst_level && rst_seen |-> !ev_rst)
        else $error("bus reset retriggered");
    a_par_gate: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) !par_on && !rd_scsi && !scsi_flags[0]
        |=> !scsi_flags[SSR_SS_PARITY])
        else $error("parity set while disabled");
    a_set_wins: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) rd_scsi && ev_sel |=>
        scsi_flags[SSR_SS_SELECTED])
        else $error("event lost on read");
    a_scsi_irq: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) |(next_scsi_flags & scsi_interrupt_enable_i)
        |=> !irq_n_o)
        else $error("scsi irq missing");
    // each event source must land in its own flag one cycle later
    a_abort_ext: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) dma_ev_i.ext_abort && parity_gen_en_i
        |=> dma_flags[SSR_DS_ABORT])
        else $error("external abort lost");
    a_step_set: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) ev_step |=> dma_flags[SSR_DS_STEP])
        else $error("single step lost");
    a_wtd_set: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) watchdog_zero_i && dma_ev_i.master_mode
        |=> dma_flags[SSR_DS_WATCHDOG])
        else $error("watchdog lost");
    a_opc_set: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) ev_opc |=> dma_flags[SSR_DS_ILLEGAL])
        else $error("illegal instruction lost");
    a_dma_irq: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) dma_irq |=> !irq_n_o)
        else $error("dma irq missing");
    // reserved dma bits never hold state, so they always read zero
    a_reserved_zero: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) dma_flags[7:5] == 3'h0)
        else $error("reserved dma bits set");
    a_rdata_idle: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) !rd_i |=> rdata_o == 8'h00)
        else $error("read data without read");
    a_mismatch_set: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) ev_ma |=> scsi_flags[SSR_SS_MISMATCH])
        else $error("phase mismatch lost");
    a_cmp_set: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) scsi_ev_i.arb_done
        |=> scsi_flags[SSR_SS_COMPLETE])
        else $error("function complete lost");
    a_timeout_set: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) sel_expired |=> scsi_flags[SSR_SS_TIMEOUT])
        else $error("selection time-out lost");
    // selection while disabled must leave a clear flag clear
    a_sel_gate: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) !selection_enable_i &&
        !scsi_flags[SSR_SS_SELECTED] |=> !scsi_flags[SSR_SS_SELECTED])
        else $error("selected while disabled");
    a_gross_set: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) scsi_ev_i.gross_error
        |=> scsi_flags[SSR_SS_GROSS])
        else $error("gross error lost");
    a_udc_set: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) ev_udc |=> scsi_flags[SSR_SS_DISCONNECT])
        else $error("disconnect lost");
    a_scsi_clr: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i) rd_scsi && scsi_set == 8'h00 |=>
        scsi_flags == 8'h00)
        else $error("scsi read did not clear");
    c_dma_irq: cover property (@(posedge clk_sys_i) dma_irq ##1 rd_dma);
    c_set_on_read: cover property (@(posedge clk_sys_i) rd_dma && ev_sir);
    c_scsi_irq: cover property (@(posedge clk_sys_i) scsi_irq ##1 rd_scsi);
    c_bus_write: cover property (@(posedge clk_sys_i) wr_bus);
    c_timeout: cover property (@(posedge clk_sys_i) sel_expired);
endmodule
`default_nettype wire

/* File: tb/ssr_scsi_peer.sv */
// scsi bus peer: drives control lines, answers a selection after delay_i cycles or never
`timescale 1ns/100ps
`default_nettype none
module ssr_scsi_peer
    import ssr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic scramble_i,
    input wire logic [7:0] hold_i,
    input wire logic sel_start_i,
    input wire logic [7:0] delay_i,
    output var ssr_lines_s lines_o,
    output logic sel_response_o
);
    logic [8:0] cnt;
    // noise each cycle when scrambling, so a stale read matches only by chance
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lines_o <= '0;
            cnt <= '0;
            sel_response_o <= 1'b0;
        end else begin
            lines_o <= scramble_i ? ssr_lines_s'(8'($urandom)) : hold_i;
            sel_response_o <= (cnt == 9'd1);
            // delay FF means the addressed device is absent
            if (sel_start_i) begin
                cnt <= (delay_i == 8'hFF) ? 9'd0 : {1'b0, delay_i};
            end else if (cnt != 9'd0) begin
                cnt <= cnt - 9'd1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the status register bank
`timescale 1ns/100ps
`default_nettype none
module tb
    import ssr_pkg::*;
;
    localparam longint TO_CYC = 20;
    logic clk_sys_i, arst_n_i, rd_i, wr_i, fifo_empty_i, sel_en, ar, pge;
    logic iswe, wz, scr, resp, irq_n_o;
    logic [7:0] addr_i, wdata_i, dctl, ctl0, den, sen, isw, hold, dly;
    logic [7:0] rdata_o, exp_ds, exp_ss;
    logic [21:0] sev;
    logic [1:0] pre;
    ssr_dma_ev_s dev;
    ssr_lines_s lines;
    ssr_scsi_ev_s sev_w;
    int n_mismatch, num_checks;
    // partner answer merged into the scsi event bundle
    assign sev_w = ssr_scsi_ev_s'(sev | ({21'h0, resp} << 14));
    ssr_status_regs #(.SEL_TIMEOUT_CYC(TO_CYC)) dut (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
        .rd_i(rd_i), .wr_i(wr_i), .wdata_i(wdata_i), .lines_i(lines),
        .fifo_empty_i(fifo_empty_i), .dma_control_i(dctl),
        .control_0_i(ctl0), .selection_enable_i(sel_en),
        .assert_reset_i(ar), .parity_gen_en_i(pge), .latch_phase_i(3'h0),
        .dma_interrupt_enable_i(den), .scsi_interrupt_enable_i(sen),
        .interrupt_status_wr_i(isw), .interrupt_status_we_i(iswe),
        .watchdog_zero_i(wz), .dma_ev_i(dev), .scsi_ev_i(sev_w),
        .rdata_o(rdata_o), .sync_clock_prescale_o(pre), .irq_n_o(irq_n_o));
    ssr_scsi_peer peer (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .scramble_i(scr),
        .hold_i(hold), .sel_start_i(sev[15]), .delay_i(dly),
        .lines_o(lines), .sel_response_o(resp));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one read cycle; the bus line register expects the edge-time lines
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] e;
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        e = (a == SSR_OFF_BUS_CTRL) ? lines : exp;
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, e);
        if (a == SSR_OFF_DMA_STAT) exp_ds = 8'h00;
        if (a == SSR_OFF_SCSI_STAT) exp_ss = 8'h00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic chk_irq();
        logic x;
        x = ((exp_ds & den & SSR_DS_EVENT_MASK) == 0) &&
            ((exp_ss & sen) == 0);
        chk({7'h00, irq_n_o}, {7'h00, x});
    endtask
    // clear both status bytes the way software must
    task automatic clr();
        rd(SSR_OFF_DMA_STAT, {fifo_empty_i, 2'b00, exp_ds[4:0]});
        repeat (10) @(posedge clk_sys_i);
        rd(SSR_OFF_SCSI_STAT, exp_ss);
    endtask
    // one-cycle event, then irq, read-clear and irq release
    task automatic ev(input logic [7:0] d, input logic [21:0] s,
        input logic w, input logic [7:0] xd, input logic [7:0] xs);
        @(posedge clk_sys_i);
        dev <= d;
        sev <= s;
        wz <= w;
        @(posedge clk_sys_i);
        dev <= 8'h00;
        sev <= '0;
        wz <= 1'b0;
        exp_ds = exp_ds | xd;
        exp_ss = exp_ss | xs;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk_irq();
        clr();
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk_irq();
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // hang guard, well beyond the fewer than a thousand cycles the tests take
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_mismatch++;
        final_report();
    end
    initial begin
        {arst_n_i, rd_i, wr_i, sel_en, ar, pge, iswe, wz, scr} = '0;
        {addr_i, wdata_i, dctl, ctl0, isw, hold, dly, dev} = '0;
        {den, sen, fifo_empty_i, sev, exp_ds, exp_ss} = '1;
        {sev, exp_ds, exp_ss} = '0;
        n_mismatch = 0;
        num_checks = 0;
        void'($urandom(40));
        repeat (10) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        rd(SSR_OFF_DMA_STAT, SSR_RST_DMA_STAT);
        wr(SSR_OFF_DMA_STAT, 8'h1F);
        wr(SSR_OFF_SCSI_STAT, 8'hFF);
        rd(SSR_OFF_SCSI_STAT, SSR_RST_SCSI_STAT);
        rd(8'h20, 8'h00);
        fifo_empty_i <= 1'b0;
        rd(SSR_OFF_DMA_STAT, 8'h00);
        $display("test reset done");
        ctl0 <= 8'h00;
        scr <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(SSR_OFF_BUS_CTRL, {6'($urandom), 2'(k)});
            chk({6'h00, pre}, 8'(k));
            rd(SSR_OFF_BUS_CTRL, 8'h00);
        end
        $display("test lines done");
        {scr, sel_en, pge} <= 3'b011;
        ctl0 <= 8'h08;
        dctl <= 8'h18;
        ev(8'h80, 0, 1'b0, 8'h10, 8'h00);
        ev(8'h40, 0, 1'b0, 8'h08, 8'h00);
        ev(8'h20, 0, 1'b0, 8'h08, 8'h00);
        ev(8'h10, 0, 1'b0, 8'h04, 8'h00);
        ev(8'h08, 0, 1'b1, 8'h02, 8'h00);
        ev(8'h00, 0, 1'b1, 8'h00, 8'h00);
        for (int k = 0; k < 3; k++) begin
            ev(8'h04 >> k, 0, 1'b0, 8'h01, 8'h00);
        end
        ev(8'h00, 22'h280000, 1'b0, 8'h00, 8'h80);
        ev(8'h00, 22'h200000, 1'b0, 8'h00, 8'h00);
        ev(8'h00, 22'h010000, 1'b0, 8'h00, 8'h40);
        ev(8'h00, 22'h002000, 1'b0, 8'h00, 8'h10);
        ev(8'h00, 22'h001000, 1'b0, 8'h00, 8'h08);
        ev(8'h00, 22'h000800, 1'b0, 8'h00, 8'h00);
        ev(8'h00, 22'h000820, 1'b0, 8'h00, 8'h00);
        ev(8'h00, 22'h000890, 1'b0, 8'h00, 8'h04);
        ev(8'h00, 22'h020800, 1'b0, 8'h00, 8'h04);
        ev(8'h00, 22'h000002, 1'b0, 8'h00, 8'h01);
        ev(8'h00, 22'h000001, 1'b0, 8'h00, 8'h01);
        {sel_en, pge} <= 2'b00;
        ctl0 <= 8'h0C;
        dctl <= 8'h00;
        ev(8'h80, 22'h002001, 1'b0, 8'h00, 8'h00);
        ev(8'h60, 22'h000000, 1'b0, 8'h00, 8'h00);
        ctl0 <= 8'h00;
        ev(8'h00, 22'h000002, 1'b0, 8'h00, 8'h00);
        {den, sen} <= 16'h0000;
        ev(8'h10, 22'h001000, 1'b0, 8'h04, 8'h08);
        {den, sen} <= 16'hFFFF;
        $display("test events done");
        // software abort through the interrupt status write
        @(posedge clk_sys_i);
        isw <= 8'h80;
        iswe <= 1'b1;
        @(posedge clk_sys_i);
        iswe <= 1'b0;
        exp_ds = 8'h10;
        clr();
        // event landing in the very cycle of the clearing read
        @(posedge clk_sys_i);
        addr_i <= SSR_OFF_DMA_STAT;
        rd_i <= 1'b1;
        dev <= 8'h10;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        dev <= 8'h00;
        exp_ds = 8'h04;
        clr();
        // long reset level must flag once only
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys_i);
            if (k == 0) ar <= 1'b1;
            else sev[2] <= 1'b1;
            repeat (6) @(posedge clk_sys_i);
            rd(SSR_OFF_SCSI_STAT, 8'h02);
            repeat (10) @(posedge clk_sys_i);
            rd(SSR_OFF_SCSI_STAT, 8'h00);
            ar <= 1'b0;
            sev <= '0;
        end
        $display("test clear done");
        // peer answers at 16, 24 or 32 cycles against a 20 cycle limit
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_sys_i);
            dly <= 8'(k * 8 + 16);
            sev[15] <= 1'b1;
            @(posedge clk_sys_i);
            sev[15] <= 1'b0;
            repeat (40) @(posedge clk_sys_i);
            exp_ss = (k > 0) ? 8'h20 : 8'h00;
            clr();
        end
        $display("test timeout done");
        final_report();
    end
endmodule
`default_nettype wire
